/* File: src/ccrf_pkg.sv */
// Purpose: Shared constants and types for the core register set.
// Assumes: One core clock, synchronous active-high reset.
// Notes: Registers are reached only through the instruction command port.
package ccrf_pkg;

  localparam int CC_C = 0;
  localparam int CC_Z = 1;
  localparam int CC_N = 2;
  localparam int CC_I0 = 3;
  localparam int CC_H = 4;
  localparam int CC_I1 = 5;
  localparam int FRAME_MAX = 5;
  localparam logic [7:0] CC_RESET = 8'he8;
  localparam logic [7:0] CC_FIXED = 8'hc0;
  localparam logic [7:0] SP_HIGH = 8'h01;
  localparam logic [7:0] SP_LOW_RESET = 8'hff;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [1:0] LVL_MAIN = 2'h2;
  localparam logic [1:0] LVL_DISABLE = 2'h3;
  localparam logic [2:0] FRAME_IRQ = 3'h5;
  localparam logic [2:0] FRAME_CALL = 3'h2;
  localparam logic [2:0] FRAME_FLAGS = 3'h1;

  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_LOAD = 5'h01, OP_ADD = 5'h02, OP_ADC = 5'h03,
    OP_SUB = 5'h04, OP_SBC = 5'h05, OP_AND = 5'h06, OP_OR = 5'h07,
    OP_XOR = 5'h08, OP_SHL = 5'h09, OP_SHR = 5'h0a, OP_ROL = 5'h0b,
    OP_ROR = 5'h0c, OP_SET_CARRY = 5'h0d, OP_CLEAR_CARRY = 5'h0e,
    OP_UNMASK_IRQ = 5'h0f, OP_MASK_IRQ = 5'h10, OP_HALT = 5'h11,
    OP_WAIT_FOR_IRQ = 5'h12, OP_PUSH_FLAGS = 5'h13, OP_POP_FLAGS = 5'h14,
    OP_BRANCH = 5'h15, OP_BIT_TEST = 5'h16, OP_JUMP = 5'h17,
    OP_CALL = 5'h18, OP_RETURN = 5'h19, OP_IRQ_ENTRY = 5'h1a,
    OP_RETURN_FROM_INTERRUPT = 5'h1b, OP_PREFIX = 5'h1c,
    OP_RESET_SP = 5'h1d
  } ccrf_op_e;

  typedef enum logic [2:0] {
    COND_HALF = 3'h0, COND_NO_HALF = 3'h1, COND_MINUS = 3'h2,
    COND_PLUS = 3'h3, COND_EQUAL = 3'h4, COND_NOT_EQUAL = 3'h5,
    COND_CARRY = 3'h6, COND_NO_CARRY = 3'h7
  } ccrf_cond_e;

  typedef enum logic [1:0] {
    DST_ACC = 2'h0, DST_X = 2'h1, DST_Y = 2'h2
  } ccrf_dst_e;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'h0, SEQ_PUSH = 3'h1, SEQ_POP_REQ = 3'h2,
    SEQ_POP_WAIT = 3'h3, SEQ_POP_DONE = 3'h4
  } ccrf_seq_e;

  typedef struct packed {
    logic valid;
    ccrf_op_e op;
    ccrf_cond_e cond;
    ccrf_dst_e dst;
    logic [1:0] len;
    logic [7:0] data;
    logic [15:0] addr;
  } ccrf_cmd_s;

  typedef struct packed {
    logic we;
    logic re;
    logic [15:0] addr;
    logic [7:0] data;
  } ccrf_stack_s;

endpackage : ccrf_pkg

/* File: src/ccrf_core_regs.sv */
// Purpose: Accumulator, index, program counter, stack pointer and flags.
// Assumes: Stack memory returns read data in the cycle re is high.
// Notes: Only the command port reaches these registers.
`timescale 1ns/100ps

module ccrf_core_regs
  import ccrf_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire ccrf_cmd_s cmd,
  input wire logic [7:0] stackRdData,
  output logic cmdReady,
  output logic [7:0] accumulator,
  output logic [7:0] indexX,
  output logic [7:0] indexY,
  output logic [15:0] programCounter,
  output logic [15:0] stackPointer,
  output logic [7:0] conditionFlags,
  output logic branchTaken,
  output ccrf_stack_s stack
);

  // ==========================================================
  // Storage
  logic [7:0] acc_reg;
  logic [7:0] x_reg;
  logic [7:0] y_reg;
  logic [7:0] pcl_reg;
  logic [7:0] pch_reg;
  logic [7:0] spLow_reg;
  logic [7:0] cc_reg;
  logic prefix_reg;
  logic ready_reg;
  logic taken_reg;
  ccrf_stack_s stack_reg;
  ccrf_seq_e seq_reg;
  logic [2:0] idx_reg;
  logic [2:0] len_reg;
  ccrf_op_e kind_reg;
  logic [7:0] frame_reg [0:FRAME_MAX-1];
  logic [7:0] frameInit [0:FRAME_MAX-1];

  logic accept;
  logic seqStart;
  logic isPush;
  logic popDone;
  logic [2:0] seqLen;
  logic [2:0] slot;
  ccrf_dst_e dstSel;
  logic [7:0] opnd;
  logic [7:0] res;
  logic [7:0] disp;
  logic [8:0] wide;
  logic [4:0] half;
  logic carryIn;
  logic wrDst;
  logic updC;
  logic updH;
  logic updNZ;
  logic cOut;
  logic taken;
  logic [15:0] pcCur;
  logic [15:0] pcSeq;
  logic [15:0] pcBranch;

  // ==========================================================
  // Command decode
  assign accept = cmd.valid && ready_reg;
  assign pcCur = {pch_reg, pcl_reg};
  assign pcSeq = pcCur + {14'h0000, cmd.len};
  assign pcBranch = pcSeq + {{8{disp[7]}}, disp};
  assign popDone = seq_reg == SEQ_POP_DONE;
  assign slot = len_reg - 3'h1 - idx_reg;
  assign carryIn = (cmd.op == OP_ADC || cmd.op == OP_SBC) && cc_reg[CC_C];

  always_comb begin
    dstSel = cmd.dst;
    if (prefix_reg && cmd.dst == DST_X) begin
      dstSel = DST_Y;
    end
  end

  always_comb begin
    seqLen = FRAME_FLAGS;
    isPush = 1'b0;
    seqStart = 1'b0;
    case (cmd.op)
      OP_IRQ_ENTRY: begin
        seqLen = FRAME_IRQ;
        isPush = 1'b1;
        seqStart = accept;
      end
      OP_CALL: begin
        seqLen = FRAME_CALL;
        isPush = 1'b1;
        seqStart = accept;
      end
      OP_PUSH_FLAGS: begin
        isPush = 1'b1;
        seqStart = accept;
      end
      OP_RETURN_FROM_INTERRUPT: begin
        seqLen = FRAME_IRQ;
        seqStart = accept;
      end
      OP_RETURN: begin
        seqLen = FRAME_CALL;
        seqStart = accept;
      end
      OP_POP_FLAGS: begin
        seqStart = accept;
      end
      default: begin
        seqStart = 1'b0;
      end
    endcase
  end

  // The saved frame leaves the second index register out.
  always_comb begin
    frameInit[0] = cc_reg;
    frameInit[1] = pcSeq[15:8];
    frameInit[2] = x_reg;
    frameInit[3] = acc_reg;
    frameInit[4] = cc_reg;
    if (cmd.op == OP_CALL) begin
      frameInit[0] = pcSeq[7:0];
    end else if (cmd.op == OP_IRQ_ENTRY) begin
      frameInit[0] = pcCur[7:0];
      frameInit[1] = pcCur[15:8];
    end
  end

  // ==========================================================
  // Arithmetic and flag results
  always_comb begin
    case (dstSel)
      DST_X: opnd = x_reg;
      DST_Y: opnd = y_reg;
      default: opnd = acc_reg;
    endcase
    half = {1'b0, opnd[3:0]} + {1'b0, cmd.data[3:0]} + {4'h0, carryIn};
    wide = 9'h000;
    res = opnd;
    disp = cmd.data;
    cOut = cc_reg[CC_C];
    wrDst = 1'b0;
    updC = 1'b0;
    updH = 1'b0;
    updNZ = 1'b0;
    taken = 1'b0;
    case (cmd.op)
      OP_LOAD: begin
        res = cmd.data;
        wrDst = 1'b1;
        updNZ = 1'b1;
      end
      OP_ADD, OP_ADC: begin
        wide = {1'b0, opnd} + {1'b0, cmd.data} + {8'h00, carryIn};
        res = wide[7:0];
        cOut = wide[8];
        wrDst = 1'b1;
        updC = 1'b1;
        updH = 1'b1;
        updNZ = 1'b1;
      end
      OP_SUB, OP_SBC: begin
        wide = {1'b0, opnd} - {1'b0, cmd.data} - {8'h00, carryIn};
        res = wide[7:0];
        cOut = wide[8];
        wrDst = 1'b1;
        updC = 1'b1;
        updNZ = 1'b1;
      end
      OP_AND, OP_OR, OP_XOR: begin
        if (cmd.op == OP_AND) begin
          res = opnd & cmd.data;
        end else if (cmd.op == OP_OR) begin
          res = opnd | cmd.data;
        end else begin
          res = opnd ^ cmd.data;
        end
        wrDst = 1'b1;
        updNZ = 1'b1;
      end
      OP_SHL, OP_ROL: begin
        res = {opnd[6:0], cmd.op == OP_ROL && cc_reg[CC_C]};
        cOut = opnd[7];
        wrDst = 1'b1;
        updC = 1'b1;
        updNZ = 1'b1;
      end
      OP_SHR, OP_ROR: begin
        res = {cmd.op == OP_ROR && cc_reg[CC_C], opnd[7:1]};
        cOut = opnd[0];
        wrDst = 1'b1;
        updC = 1'b1;
        updNZ = 1'b1;
      end
      OP_SET_CARRY, OP_CLEAR_CARRY: begin
        cOut = cmd.op == OP_SET_CARRY;
        updC = 1'b1;
      end
      OP_BIT_TEST: begin
        cOut = cmd.data[cmd.cond];
        updC = 1'b1;
        taken = cOut;
        disp = cmd.addr[7:0];
      end
      OP_BRANCH: begin
        case (cmd.cond)
          COND_HALF: taken = cc_reg[CC_H];
          COND_NO_HALF: taken = !cc_reg[CC_H];
          COND_MINUS: taken = cc_reg[CC_N];
          COND_PLUS: taken = !cc_reg[CC_N];
          COND_EQUAL: taken = cc_reg[CC_Z];
          COND_NOT_EQUAL: taken = !cc_reg[CC_Z];
          COND_CARRY: taken = cc_reg[CC_C];
          default: taken = !cc_reg[CC_C];
        endcase
      end
      default: begin
        taken = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Data registers
  always_ff @(posedge clock) begin
    if (reset) begin
      acc_reg <= 8'h00;
    end else if (popDone && kind_reg == OP_RETURN_FROM_INTERRUPT) begin
      acc_reg <= frame_reg[3];
    end else if (accept && wrDst && dstSel == DST_ACC) begin
      acc_reg <= res;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      x_reg <= 8'h00;
    end else if (popDone && kind_reg == OP_RETURN_FROM_INTERRUPT) begin
      x_reg <= frame_reg[2];
    end else if (accept && wrDst && dstSel == DST_X) begin
      x_reg <= res;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      y_reg <= 8'h00;
    end else if (accept && wrDst && dstSel == DST_Y) begin
      y_reg <= res;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      prefix_reg <= 1'b0;
    end else if (accept) begin
      prefix_reg <= cmd.op == OP_PREFIX;
    end
  end

  // ==========================================================
  // Program counter and stack pointer
  always_ff @(posedge clock) begin
    if (reset) begin
      {pch_reg, pcl_reg} <= PC_RESET;
    end else if (popDone && (kind_reg == OP_RETURN ||
                 kind_reg == OP_RETURN_FROM_INTERRUPT)) begin
      {pch_reg, pcl_reg} <= {frame_reg[1], frame_reg[0]};
    end else if (accept) begin
      case (cmd.op)
        OP_JUMP, OP_CALL, OP_IRQ_ENTRY: begin
          {pch_reg, pcl_reg} <= cmd.addr;
        end
        OP_RETURN, OP_RETURN_FROM_INTERRUPT: begin
          {pch_reg, pcl_reg} <= pcCur;
        end
        default: begin
          {pch_reg, pcl_reg} <= taken ? pcBranch : pcSeq;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      spLow_reg <= SP_LOW_RESET;
    end else if (seq_reg == SEQ_PUSH) begin
      spLow_reg <= spLow_reg - 8'h01;
    end else if (seq_reg == SEQ_POP_REQ) begin
      spLow_reg <= spLow_reg + 8'h01;
    end else if (accept && cmd.op == OP_RESET_SP) begin
      spLow_reg <= SP_LOW_RESET;
    end
  end

  // ==========================================================
  // Condition flags
  always_ff @(posedge clock) begin
    if (reset) begin
      cc_reg <= CC_RESET;
    end else if (popDone && kind_reg != OP_RETURN) begin
      cc_reg <= frame_reg[len_reg - 3'h1] | CC_FIXED;
    end else if (accept) begin
      if (updC) begin
        cc_reg[CC_C] <= cOut;
      end
      if (updH) begin
        cc_reg[CC_H] <= half[4];
      end
      if (updNZ) begin
        cc_reg[CC_N] <= res[7];
        cc_reg[CC_Z] <= res == 8'h00;
      end
      case (cmd.op)
        OP_UNMASK_IRQ, OP_HALT, OP_WAIT_FOR_IRQ: begin
          {cc_reg[CC_I1], cc_reg[CC_I0]} <= LVL_MAIN;
        end
        OP_MASK_IRQ: begin
          {cc_reg[CC_I1], cc_reg[CC_I0]} <= LVL_DISABLE;
        end
        OP_IRQ_ENTRY: begin
          {cc_reg[CC_I1], cc_reg[CC_I0]} <= cmd.data[1:0];
        end
        default: begin
          cc_reg[CC_I0] <= cc_reg[CC_I0];
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      taken_reg <= 1'b0;
    end else begin
      taken_reg <= accept && taken;
    end
  end

  // ==========================================================
  // Stack sequencer
  always_ff @(posedge clock) begin
    if (reset) begin
      seq_reg <= SEQ_IDLE;
      idx_reg <= 3'h0;
      len_reg <= 3'h0;
      kind_reg <= OP_NOP;
      ready_reg <= 1'b1;
      stack_reg <= '0;
      for (int i = 0; i < FRAME_MAX; i++) begin
        frame_reg[i] <= 8'h00;
      end
    end else begin
      stack_reg.we <= 1'b0;
      stack_reg.re <= 1'b0;
      case (seq_reg)
        SEQ_IDLE: begin
          if (seqStart) begin
            kind_reg <= cmd.op;
            len_reg <= seqLen;
            idx_reg <= 3'h0;
            ready_reg <= 1'b0;
            seq_reg <= isPush ? SEQ_PUSH : SEQ_POP_REQ;
            for (int i = 0; i < FRAME_MAX; i++) begin
              frame_reg[i] <= frameInit[i];
            end
          end
        end
        SEQ_PUSH: begin
          stack_reg.we <= 1'b1;
          stack_reg.addr <= {SP_HIGH, spLow_reg};
          stack_reg.data <= frame_reg[idx_reg];
          idx_reg <= idx_reg + 3'h1;
          if (idx_reg == len_reg - 3'h1) begin
            seq_reg <= SEQ_IDLE;
            ready_reg <= 1'b1;
          end
        end
        SEQ_POP_REQ: begin
          stack_reg.re <= 1'b1;
          stack_reg.addr <= {SP_HIGH, spLow_reg + 8'h01};
          seq_reg <= SEQ_POP_WAIT;
        end
        SEQ_POP_WAIT: begin
          frame_reg[slot] <= stackRdData;
          idx_reg <= idx_reg + 3'h1;
          if (idx_reg == len_reg - 3'h1) begin
            seq_reg <= SEQ_POP_DONE;
          end else begin
            seq_reg <= SEQ_POP_REQ;
          end
        end
        default: begin
          seq_reg <= SEQ_IDLE;
          ready_reg <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // Outputs
  assign cmdReady = ready_reg;
  assign accumulator = acc_reg;
  assign indexX = x_reg;
  assign indexY = y_reg;
  assign programCounter = {pch_reg, pcl_reg};
  assign stackPointer = {SP_HIGH, spLow_reg};
  assign conditionFlags = cc_reg;
  assign branchTaken = taken_reg;
  assign stack = stack_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence irqTaken;
    accept && cmd.op == OP_IRQ_ENTRY;
  endsequence

  sequence fivePushes;
    stack.we [*5] ##1 !stack.we;
  endsequence

  AST_TOP_ONES: assert property (conditionFlags[7:6] == 2'h3)
    else $error("Flag bits 7 and 6 not one.");
  AST_SP_HIGH: assert property (stackPointer[15:8] == SP_HIGH)
    else $error("Stack pointer high byte changed.");
  AST_IRQ_FIVE: assert property (irqTaken |-> ##2 fivePushes)
    else $error("Interrupt entry did not push five bytes.");
  AST_IRQ_PCL: assert property (irqTaken |->
    ##2 stack.data == $past(programCounter[7:0], 2))
    else $error("First pushed byte is not program counter low.");
  AST_Y_KEPT: assert property (irqTaken |=> $stable(indexY) [*6])
    else $error("Second index changed during context save.");
  AST_PRIO_LOAD: assert property (irqTaken |=>
    {conditionFlags[CC_I1], conditionFlags[CC_I0]} == $past(cmd.data[1:0]))
    else $error("Mask bits not loaded on interrupt entry.");
  AST_HALF: assert property ((accept && cmd.op == OP_ADD &&
    cmd.dst == DST_ACC && !prefix_reg) |=> conditionFlags[CC_H] ==
    ((5'($past(accumulator[3:0])) + 5'($past(cmd.data[3:0]))) > 5'h0f))
    else $error("Half carry wrong after add.");
  AST_NEG_ZERO: assert property ((accept && wrDst &&
    dstSel == DST_ACC) |=> conditionFlags[CC_N] == accumulator[7] &&
    conditionFlags[CC_Z] == (accumulator == 8'h00))
    else $error("Negative or zero flag does not match result.");
  AST_SET_CARRY: assert property ((accept && cmd.op == OP_SET_CARRY) |=>
    conditionFlags[CC_C] && $stable(conditionFlags[7:1]))
    else $error("Set carry wrong or touched other flags.");
  AST_BRANCH_EQ: assert property ((accept && cmd.op == OP_BRANCH &&
    cmd.cond == COND_EQUAL) |=> branchTaken == $past(conditionFlags[CC_Z]))
    else $error("Equal branch decision wrong.");
  AST_PREFIX_Y: assert property ((accept && cmd.op == OP_LOAD &&
    cmd.dst == DST_X && prefix_reg) |=> indexY == $past(cmd.data) &&
    $stable(indexX))
    else $error("Prefixed load did not reach second index.");
  AST_UNMASK: assert property ((accept && cmd.op == OP_UNMASK_IRQ) |=>
    {conditionFlags[CC_I1], conditionFlags[CC_I0]} == LVL_MAIN)
    else $error("Unmask did not select main level.");

endmodule : ccrf_core_regs

/* File: verification/testbench.sv */
// Purpose: Self-checking bench for the core register set.
// Assumes: Commands are driven on the falling clock edge.
// Notes: The bench models the stack memory with a combinational read.
`timescale 1ns/100ps

module testbench
  import ccrf_pkg::*;
;
  typedef struct packed {
    ccrf_op_e op;
    logic [7:0] d;
    logic [7:0] acc;
    logic [7:0] fl;
  } ccrf_tb_row_s;

  logic clock;
  logic reset;
  ccrf_cmd_s cmd;
  logic [7:0] stackRdData;
  logic cmdReady;
  logic [7:0] accumulator;
  logic [7:0] indexX;
  logic [7:0] indexY;
  logic [15:0] programCounter;
  logic [15:0] stackPointer;
  logic [7:0] conditionFlags;
  logic branchTaken;
  ccrf_stack_s stack;
  logic [7:0] mem [256];
  logic [15:0] wrAddr [$];
  logic [7:0] wrData [$];
  int n_fail;
  int checked;
  int cycles;
  ccrf_tb_row_s rows [21];
  logic [7:0] pushExp [5];

  ccrf_core_regs u_ccrf_core_regs (
    .clock(clock),
    .reset(reset),
    .cmd(cmd),
    .stackRdData(stackRdData),
    .cmdReady(cmdReady),
    .accumulator(accumulator),
    .indexX(indexX),
    .indexY(indexY),
    .programCounter(programCounter),
    .stackPointer(stackPointer),
    .conditionFlags(conditionFlags),
    .branchTaken(branchTaken),
    .stack(stack)
  );

  // Between reads the data line shows a changed value, never the last one.
  assign stackRdData = stack.re ? mem[stack.addr[7:0]] : ~mem[stack.addr[7:0]];

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  always @(posedge clock) begin
    if (stack.we) begin
      mem[stack.addr[7:0]] <= stack.data;
      wrAddr.push_back(stack.addr);
      wrData.push_back(stack.data);
    end
    cycles <= cycles + 1;
    if (cycles > 3000) begin
      n_fail = n_fail + 1;
      complete_run();
    end
  end

  task automatic check(string name, logic [15:0] exp, logic [15:0] got);
    checked = checked + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  // Called on a falling edge; returns on the next one, request still up.
  task automatic issue(ccrf_op_e op, logic [7:0] d, ccrf_dst_e dst = DST_ACC,
                       ccrf_cond_e cnd = COND_HALF, logic [15:0] a = 16'h0);
    cmd.valid = 1'b1;
    cmd.op = op;
    cmd.data = d;
    cmd.dst = dst;
    cmd.cond = cnd;
    cmd.addr = a;
    cmd.len = (op == OP_IRQ_ENTRY) ? 2'h0 : 2'h1;
    @(negedge clock);
  endtask : issue

  task automatic wait_ready();
    int i;
    i = 0;
    while (cmdReady !== 1'b1 && i < 40) begin
      @(negedge clock);
      i = i + 1;
    end
    check("cmdReady wait", 16'h1, {15'h0, cmdReady});
  endtask : wait_ready

  initial begin
    n_fail = 0;
    checked = 0;
    cycles = 0;
    for (int i = 0; i < 256; i++) mem[i] = 8'h00;
    cmd = '0;
    reset = 1'b1;
    rows = '{
      '{OP_LOAD, 8'h0f, 8'h0f, 8'he8}, '{OP_ADD, 8'h01, 8'h10, 8'hf8},
      '{OP_ADD, 8'hf0, 8'h00, 8'heb}, '{OP_ADC, 8'h00, 8'h01, 8'he8},
      '{OP_SUB, 8'h02, 8'hff, 8'hed}, '{OP_AND, 8'h0f, 8'h0f, 8'he9},
      '{OP_OR, 8'h80, 8'h8f, 8'hed}, '{OP_XOR, 8'h8f, 8'h00, 8'heb},
      '{OP_CLEAR_CARRY, 8'h00, 8'h00, 8'hea},
      '{OP_SET_CARRY, 8'h00, 8'h00, 8'heb},
      '{OP_LOAD, 8'h81, 8'h81, 8'hed}, '{OP_SHL, 8'h00, 8'h02, 8'he9},
      '{OP_SHR, 8'h00, 8'h01, 8'he8}, '{OP_SET_CARRY, 8'h00, 8'h01, 8'he9},
      '{OP_SBC, 8'h00, 8'h00, 8'hea}, '{OP_MASK_IRQ, 8'h00, 8'h00, 8'hea},
      '{OP_UNMASK_IRQ, 8'h00, 8'h00, 8'he2},
      '{OP_MASK_IRQ, 8'h00, 8'h00, 8'hea}, '{OP_HALT, 8'h00, 8'h00, 8'he2},
      '{OP_MASK_IRQ, 8'h00, 8'h00, 8'hea},
      '{OP_WAIT_FOR_IRQ, 8'h00, 8'h00, 8'he2}};
    repeat (4) @(negedge clock);
    reset = 1'b0;
    check("flags", 16'h00e8, {8'h0, conditionFlags});
    check("sp", 16'h01ff, stackPointer);
    check("pc", 16'h0000, programCounter);
    check("ready", 16'h1, {15'h0, cmdReady});
    // ==========================================================
    // Back-to-back single-cycle operations
    for (int i = 0; i < 21; i++) begin
      issue(rows[i].op, rows[i].d);
      check("acc", {8'h0, rows[i].acc}, {8'h0, accumulator});
      check("flags", {8'h0, rows[i].fl}, {8'h0, conditionFlags});
      check("pc", 16'(i + 1), programCounter);
    end
    // ==========================================================
    // Index registers and the prefix
    issue(OP_LOAD, 8'h55, DST_X);
    issue(OP_PREFIX, 8'h00);
    issue(OP_LOAD, 8'haa, DST_X);
    check("y", 16'h00aa, {8'h0, indexY});
    check("x", 16'h0055, {8'h0, indexX});
    check("flags", 16'h00e4, {8'h0, conditionFlags});
    issue(OP_LOAD, 8'h33, DST_X);
    check("x", 16'h0033, {8'h0, indexX});
    issue(OP_LOAD, 8'h5a);
    check("pc", 16'd26, programCounter);
    // ==========================================================
    // Interrupt entry, a refused request, and the return
    issue(OP_IRQ_ENTRY, 8'h01, DST_ACC, COND_HALF, 16'h1234);
    check("flags", 16'h00c8, {8'h0, conditionFlags});
    check("pc", 16'h1234, programCounter);
    check("ready", 16'h0, {15'h0, cmdReady});
    issue(OP_LOAD, 8'hff);
    cmd.valid = 1'b0;
    wait_ready();
    @(negedge clock);
    pushExp = '{8'h1a, 8'h00, 8'h33, 8'h5a, 8'he0};
    check("push count", 16'd5, 16'(wrAddr.size()));
    for (int i = 0; i < 5 && i < wrAddr.size(); i++) begin
      check("push addr", 16'h01ff - 16'(i), wrAddr[i]);
      check("push data", {8'h0, pushExp[i]}, {8'h0, wrData[i]});
    end
    check("acc", 16'h005a, {8'h0, accumulator});
    check("sp", 16'h01fa, stackPointer);
    check("y", 16'h00aa, {8'h0, indexY});
    issue(OP_LOAD, 8'h00);
    issue(OP_LOAD, 8'h00, DST_X);
    issue(OP_RETURN_FROM_INTERRUPT, 8'h00);
    cmd.valid = 1'b0;
    wait_ready();
    check("acc", 16'h005a, {8'h0, accumulator});
    check("x", 16'h0033, {8'h0, indexX});
    check("pc", 16'h001a, programCounter);
    check("flags", 16'h00e0, {8'h0, conditionFlags});
    check("sp", 16'h01ff, stackPointer);
    check("y", 16'h00aa, {8'h0, indexY});
    // ==========================================================
    // Every branch condition, with Z and C set, H and N clear
    issue(OP_LOAD, 8'h00);
    issue(OP_SET_CARRY, 8'h00);
    check("flags", 16'h00e3, {8'h0, conditionFlags});
    for (int c = 0; c < 8; c++) begin
      issue(OP_BRANCH, 8'h04, DST_ACC, ccrf_cond_e'(c));
      check("taken", {15'h0, (c == 1 || c == 3 || c == 4 || c == 6)},
            {15'h0, branchTaken});
    end
    // ==========================================================
    // Jump, call, flag push and pop, return, bit test, stack reset
    issue(OP_JUMP, 8'h00, DST_ACC, COND_HALF, 16'h0400);
    check("pc", 16'h0400, programCounter);
    issue(OP_CALL, 8'h00, DST_ACC, COND_HALF, 16'h0800);
    cmd.valid = 1'b0;
    wait_ready();
    issue(OP_PUSH_FLAGS, 8'h00);
    cmd.valid = 1'b0;
    wait_ready();
    check("pc", 16'h0801, programCounter);
    check("sp", 16'h01fc, stackPointer);
    check("push data", 16'h0004, {8'h0, wrData[6]});
    issue(OP_LOAD, 8'h80);
    issue(OP_POP_FLAGS, 8'h00);
    cmd.valid = 1'b0;
    wait_ready();
    check("flags", 16'h00e3, {8'h0, conditionFlags});
    issue(OP_RETURN, 8'h00);
    cmd.valid = 1'b0;
    wait_ready();
    check("pc", 16'h0401, programCounter);
    check("sp", 16'h01ff, stackPointer);
    issue(OP_BIT_TEST, 8'h04, DST_ACC, COND_PLUS, 16'h0010);
    check("flags", 16'h00e2, {8'h0, conditionFlags});
    check("taken", 16'h0, {15'h0, branchTaken});
    issue(OP_BIT_TEST, 8'h04, DST_ACC, COND_MINUS, 16'h0010);
    check("flags", 16'h00e3, {8'h0, conditionFlags});
    check("taken", 16'h1, {15'h0, branchTaken});
    issue(OP_PUSH_FLAGS, 8'h00);
    cmd.valid = 1'b0;
    wait_ready();
    check("sp", 16'h01fe, stackPointer);
    issue(OP_RESET_SP, 8'h00);
    check("sp", 16'h01ff, stackPointer);
    check("push count", 16'd9, 16'(wrAddr.size()));
    cmd.valid = 1'b0;
    // ==========================================================
    // A second reset in mid-run
    @(negedge clock);
    reset = 1'b1;
    @(negedge clock);
    reset = 1'b0;
    check("flags", 16'h00e8, {8'h0, conditionFlags});
    check("sp", 16'h01ff, stackPointer);
    check("acc", 16'h0000, {8'h0, accumulator});
    check("pc", 16'h0000, programCounter);
    complete_run();
  end

endmodule : testbench
